// >>> logic/occfg_top.sv
// output configuration register with its serial write port and output settings
`timescale 1ns/1ps
`include "occfg_cfg.svh"

module occfg_top (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  input  wire logic       SCLK,
  input  wire logic       SCS_B,
  input  wire logic       SDATA,
  input  wire logic       EXT_MODE,
  input  wire logic       SWING_SELECT_PIN,
  input  wire logic       EDGE_SELECT_PIN,
  output logic            DUTY_STABILIZER_ENABLE,
  output logic            DDR_CLOCK_PHASE_SELECT,
  output logic            DOUBLE_RATE_DISABLE,
  output logic            OUTPUT_SWING_SELECT,
  output logic            OUTPUT_EDGE_SELECT,
  output logic [1:0]      LAUNCH_MODE,
  output logic            WRITE_STROBE
);

  logic                   bit_stb;
  logic                   bit_val;
  logic                   frm_open;
  logic                   frm_close;

  occfg_pkg::occfg_state_e state_r;
  occfg_pkg::occfg_state_e state_nxt;
  logic [4:0]             cnt_r;
  logic [4:0]             cnt_nxt;
  logic [15:0]            shreg_r;
  logic [15:0]            shreg_nxt;
  logic [3:0]             addr_r;
  logic [3:0]             addr_nxt;
  logic [15:0]            cfg_r;
  logic [15:0]            cfg_nxt;
  logic                   wstb_nxt;

  logic                   stab_r;
  logic                   phase_r;
  logic                   sdr_r;
  logic                   swing_r;
  logic                   edge_r;
  logic [1:0]             launch_r;
  logic                   wstb_r;
  logic                   stab_nxt;
  logic                   phase_nxt;
  logic                   sdr_nxt;
  logic                   swing_nxt;
  logic                   edge_nxt;
  occfg_pkg::occfg_launch_e launch_nxt;

  // register bit in extended mode, pin level or power-on value in normal mode
  function automatic logic pick(input logic ext, input logic reg_bit, input logic pin_bit);
    pick = ext ? reg_bit : pin_bit;
  endfunction

  // one serial bit into the low end of the shift image
  function automatic logic [15:0] shift_in(input logic [15:0] img, input logic b);
    shift_in = {img[14:0], b};
  endfunction

  // frame position step; wraps are prevented by the field limits
  function automatic logic [4:0] bump(input logic [4:0] n);
    bump = n + 5'h01;
  endfunction

  occfg_bitrx u_bitrx (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .sclk      (SCLK),
    .scs_b     (SCS_B),
    .sdata     (SDATA),
    .bit_stb   (bit_stb),
    .bit_val   (bit_val),
    .frm_open  (frm_open),
    .frm_close (frm_close)
  );

  // frame parser: header, address, data, then wait for select to rise
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shreg_nxt = shreg_r;
    addr_nxt  = addr_r;
    cfg_nxt   = cfg_r;
    wstb_nxt  = 1'h0;
    if (frm_close) begin
      // only a frame of exactly the full length commits
      if (state_r == occfg_pkg::ST_DONE && addr_r == `OCCFG_CFG_ADDR) begin
        cfg_nxt  = shreg_r;
        wstb_nxt = 1'h1;
      end
      // other addresses end here with no effect on the settings
      state_nxt = occfg_pkg::ST_IDLE;
    end else if (frm_open) begin
      state_nxt = occfg_pkg::ST_HEADER;
      cnt_nxt   = 5'h00;
      shreg_nxt = 16'h0000;
    end else if (bit_stb) begin
      unique case (state_r)
        occfg_pkg::ST_IDLE: begin
          state_nxt = occfg_pkg::ST_IDLE;
        end
        occfg_pkg::ST_HEADER: begin
          shreg_nxt = shift_in(shreg_r, bit_val);
          cnt_nxt   = bump(cnt_r);
          if (cnt_r == `OCCFG_HDR_LAST) begin
            cnt_nxt = 5'h00;
            if ({shreg_r[6:0], bit_val} == `OCCFG_HDR_PATTERN) begin
              state_nxt = occfg_pkg::ST_ADDR;
            end else begin
              state_nxt = occfg_pkg::ST_DROP;
            end
          end
        end
        occfg_pkg::ST_ADDR: begin
          addr_nxt = {addr_r[2:0], bit_val};
          cnt_nxt  = bump(cnt_r);
          if (cnt_r == `OCCFG_ADDR_LAST) begin
            cnt_nxt   = 5'h00;
            state_nxt = occfg_pkg::ST_DATA;
          end
        end
        occfg_pkg::ST_DATA: begin
          shreg_nxt = shift_in(shreg_r, bit_val);
          cnt_nxt   = bump(cnt_r);
          if (cnt_r == `OCCFG_DATA_LAST) begin
            cnt_nxt   = 5'h00;
            state_nxt = occfg_pkg::ST_DONE;
          end
        end
        occfg_pkg::ST_DONE: begin
          // an overlong frame is thrown away rather than half applied
          state_nxt = occfg_pkg::ST_DROP;
        end
        occfg_pkg::ST_DROP: begin
          state_nxt = occfg_pkg::ST_DROP;
        end
        default: begin
          state_nxt = occfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // the fixed bits are the writer's duty and are stored as sent
  // no read path exists: only the setting bits of the stored image reach the ports, and only in extended mode
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= occfg_pkg::ST_IDLE;
      cnt_r   <= 5'h00;
      shreg_r <= 16'h0000;
      addr_r  <= 4'h0;
      cfg_r   <= `OCCFG_CFG_RESET;
      wstb_r  <= 1'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shreg_r <= shreg_nxt;
      addr_r  <= addr_nxt;
      cfg_r   <= cfg_nxt;
      wstb_r  <= wstb_nxt;
    end
  end

  // effective settings; normal mode uses pins or the power-on values
  always_comb begin
    stab_nxt  = pick(EXT_MODE, cfg_r[`OCCFG_BIT_STAB], `OCCFG_RST_STAB);
    sdr_nxt   = pick(EXT_MODE, cfg_r[`OCCFG_BIT_SDR], `OCCFG_RST_SDR);
    // phase forced to aligned in single rate, where it means nothing
    phase_nxt = pick(EXT_MODE, cfg_r[`OCCFG_BIT_PHASE], `OCCFG_RST_PHASE)
                & ~sdr_nxt;
    swing_nxt = pick(EXT_MODE, cfg_r[`OCCFG_BIT_SWING], SWING_SELECT_PIN);
    edge_nxt  = pick(EXT_MODE, cfg_r[`OCCFG_BIT_EDGE], EDGE_SELECT_PIN);
    if (sdr_nxt) begin
      launch_nxt = edge_nxt ? occfg_pkg::LM_SDR_RISE : occfg_pkg::LM_SDR_FALL;
    end else begin
      launch_nxt = phase_nxt ? occfg_pkg::LM_DDR_CENTER : occfg_pkg::LM_DDR_ALIGN;
    end
  end

  // settings are registered so every output comes from a flop
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      stab_r   <= `OCCFG_RST_STAB;
      phase_r  <= `OCCFG_RST_PHASE;
      sdr_r    <= `OCCFG_RST_SDR;
      swing_r  <= `OCCFG_RST_SWING;
      edge_r   <= `OCCFG_RST_EDGE;
      launch_r <= `OCCFG_RST_LAUNCH;
    end else begin
      stab_r   <= stab_nxt;
      phase_r  <= phase_nxt;
      sdr_r    <= sdr_nxt;
      swing_r  <= swing_nxt;
      edge_r   <= edge_nxt;
      launch_r <= launch_nxt;
    end
  end

  assign DUTY_STABILIZER_ENABLE = stab_r;
  assign DDR_CLOCK_PHASE_SELECT = phase_r;
  assign DOUBLE_RATE_DISABLE    = sdr_r;
  assign OUTPUT_SWING_SELECT    = swing_r;
  assign OUTPUT_EDGE_SELECT     = edge_r;
  assign LAUNCH_MODE            = launch_r;
  assign WRITE_STROBE           = wstb_r;

endmodule // occfg_top

// >>> logic/occfg_cfg.svh
// offsets, field positions, reset values and frame counts of the output configuration block
`ifndef OCCFG_CFG_SVH
`define OCCFG_CFG_SVH

`define OCCFG_CFG_ADDR     4'h1
`define OCCFG_CFG_RESET    16'hb2ff
`define OCCFG_BIT_STAB     12
`define OCCFG_BIT_PHASE    11
`define OCCFG_BIT_SDR      10
`define OCCFG_BIT_SWING    9
`define OCCFG_BIT_EDGE     8
`define OCCFG_RST_STAB     1'h1
`define OCCFG_RST_PHASE    1'h0
`define OCCFG_RST_SDR      1'h0
`define OCCFG_RST_SWING    1'h1
`define OCCFG_RST_EDGE     1'h0
`define OCCFG_RST_LAUNCH   2'h0
`define OCCFG_HDR_PATTERN  8'ha5
`define OCCFG_HDR_LAST     5'h07
`define OCCFG_ADDR_LAST    5'h03
`define OCCFG_DATA_LAST    5'h0f

`endif

// >>> logic/occfg_pkg.sv
// types shared by the output configuration block
package occfg_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_HEADER = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DATA   = 3'b011,
    ST_DONE   = 3'b100,
    ST_DROP   = 3'b101
  } occfg_state_e;

  typedef enum logic [1:0] {
    LM_DDR_ALIGN  = 2'b00,
    LM_DDR_CENTER = 2'b01,
    LM_SDR_FALL   = 2'b10,
    LM_SDR_RISE   = 2'b11
  } occfg_launch_e;

endpackage

// >>> logic/occfg_bitrx.sv
// serial pin front end: bit strobes and frame open and close pulses
`timescale 1ns/1ps
module occfg_bitrx (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic sclk,
  input  wire logic scs_b,
  input  wire logic sdata,
  output logic      bit_stb,
  output logic      bit_val,
  output logic      frm_open,
  output logic      frm_close
);

  logic sclk_prev_r;
  logic scs_prev_r;
  logic bit_stb_r;
  logic bit_val_r;
  logic frm_open_r;
  logic frm_close_r;
  logic bit_stb_nxt;
  logic bit_val_nxt;
  logic frm_open_nxt;
  logic frm_close_nxt;

  // data is taken on the serial clock rising edge while select is low
  always_comb begin
    bit_stb_nxt   = sclk & ~sclk_prev_r & ~scs_b & ~scs_prev_r;
    bit_val_nxt   = sdata;
    frm_open_nxt  = ~scs_b & scs_prev_r;
    frm_close_nxt = scs_b & ~scs_prev_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_r <= 1'h0;
      scs_prev_r  <= 1'h1;
      bit_stb_r   <= 1'h0;
      bit_val_r   <= 1'h0;
      frm_open_r  <= 1'h0;
      frm_close_r <= 1'h0;
    end else begin
      sclk_prev_r <= sclk;
      scs_prev_r  <= scs_b;
      bit_stb_r   <= bit_stb_nxt;
      bit_val_r   <= bit_val_nxt;
      frm_open_r  <= frm_open_nxt;
      frm_close_r <= frm_close_nxt;
    end
  end

  assign bit_stb   = bit_stb_r;
  assign bit_val   = bit_val_r;
  assign frm_open  = frm_open_r;
  assign frm_close = frm_close_r;

endmodule // occfg_bitrx

// >>> testbench/occfg_host.sv
// host model driving the serial write port
`timescale 1ns/1ps
module occfg_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      scs_b,
  output logic      sdata
);
  initial begin
    sclk = 1'h0;
    scs_b = 1'h1;
    sdata = 1'h0;
  end
  // caller builds header, address and fixed bits
  task automatic send(input logic [28:0] frm, input int nbits);
    @(negedge clk);
    scs_b = 1'h0;
    for (int i = nbits - 1; i >= 0; i--) begin
      @(negedge clk);
      sclk = 1'h1;
      sdata = frm[i];
      @(negedge clk);
      sclk = 1'h0;
    end
    repeat (2) @(negedge clk);
    scs_b = 1'h1;
    // released line shows no stale bit
    sdata = ~sdata;
  endtask
endmodule // occfg_host

// >>> testbench/occfg_top_checker.sv
// port checks of the output configuration block
`timescale 1ns/1ps
module occfg_top_checker (
  input wire logic       CLK_SYS,
  input wire logic       RST_B,
  input wire logic       SCS_B,
  input wire logic       EXT_MODE,
  input wire logic       SWING_SELECT_PIN,
  input wire logic       EDGE_SELECT_PIN,
  input wire logic       DUTY_STABILIZER_ENABLE,
  input wire logic       DDR_CLOCK_PHASE_SELECT,
  input wire logic       DOUBLE_RATE_DISABLE,
  input wire logic       OUTPUT_SWING_SELECT,
  input wire logic       OUTPUT_EDGE_SELECT,
  input wire logic [1:0] LAUNCH_MODE,
  input wire logic       WRITE_STROBE
);
  logic [6:0] c;
  assign c = {DUTY_STABILIZER_ENABLE, DDR_CLOCK_PHASE_SELECT, DOUBLE_RATE_DISABLE,
              OUTPUT_SWING_SELECT, OUTPUT_EDGE_SELECT, LAUNCH_MODE};
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  sequence strb_pulse; WRITE_STROBE ##1 !WRITE_STROBE; endsequence
  sequence frm_closed; $past(SCS_B, 2) && !$past(SCS_B, 3); endsequence
  strobe_pulse_a:
    assert property (WRITE_STROBE |-> strb_pulse) else $error("strobe too long");
  strobe_delay_a:
    assert property (WRITE_STROBE |-> frm_closed) else $error("strobe at wrong time");
  phase_mask_a:
    assert property (c[4] |-> !c[5]) else $error("phase not masked");
  launch_map_a:
    assert property (c[1:0] == {c[4], c[4] ? c[2] : c[5]}) else $error("bad launch mode");
  normal_fixed_a:
    assert property ($past(RST_B) && !$past(EXT_MODE) |-> c[6:4] == 3'h4)
      else $error("normal mode uses register");
  swing_pin_a:
    assert property ($past(RST_B) && !$past(EXT_MODE) |-> c[3] == $past(SWING_SELECT_PIN))
      else $error("swing not from pin");
  edge_pin_a:
    assert property ($past(RST_B) && !$past(EXT_MODE) |-> c[2] == $past(EDGE_SELECT_PIN))
      else $error("edge not from pin");
  hold_cfg_a:
    assert property ($past(RST_B) && $past(RST_B, 2) && $past(EXT_MODE) && $past(EXT_MODE, 2)
      && !$past(WRITE_STROBE) |-> $stable(c)) else $error("setting changed unwritten");
  reset_vals_a:
    assert property (disable iff (1'h0) !RST_B |-> c == 7'h48 && !WRITE_STROBE)
      else $error("bad reset value");
endmodule // occfg_top_checker
bind occfg_top occfg_top_checker occfg_top_checker_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
  .SCS_B(SCS_B), .EXT_MODE(EXT_MODE), .SWING_SELECT_PIN(SWING_SELECT_PIN),
  .EDGE_SELECT_PIN(EDGE_SELECT_PIN), .DUTY_STABILIZER_ENABLE(DUTY_STABILIZER_ENABLE),
  .DDR_CLOCK_PHASE_SELECT(DDR_CLOCK_PHASE_SELECT), .DOUBLE_RATE_DISABLE(DOUBLE_RATE_DISABLE),
  .OUTPUT_SWING_SELECT(OUTPUT_SWING_SELECT), .OUTPUT_EDGE_SELECT(OUTPUT_EDGE_SELECT),
  .LAUNCH_MODE(LAUNCH_MODE), .WRITE_STROBE(WRITE_STROBE));

// >>> testbench/occfg_top_tb_top.sv
// self-checking bench for the output configuration block
`timescale 1ns/1ps
`include "occfg_cfg.svh"
module occfg_top_tb_top;
  // clock starts high so reset can fall on a falling edge before any rising one
  logic       CLK_SYS = 1'h1;
  logic       RST_B = 1'h1;
  logic       EXT_MODE = 1'h1;
  logic       SWING_SELECT_PIN = 1'h0;
  logic       EDGE_SELECT_PIN = 1'h1;
  logic       SCLK, SCS_B, SDATA, WRITE_STROBE, DUTY, PHASE, DRD, SWING, EDGE;
  logic [1:0] LAUNCH_MODE;
  logic [7:0] cfg;
  int         bad_count = 0;
  int         checked = 0;
  assign cfg = {WRITE_STROBE, DUTY, PHASE, DRD, SWING, EDGE, LAUNCH_MODE};
  always #2.5 CLK_SYS = ~CLK_SYS;
  occfg_host occfg_host_inst (.clk(CLK_SYS), .sclk(SCLK), .scs_b(SCS_B), .sdata(SDATA));
  occfg_top occfg_top_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .SCLK(SCLK), .SCS_B(SCS_B),
    .SDATA(SDATA), .EXT_MODE(EXT_MODE), .SWING_SELECT_PIN(SWING_SELECT_PIN),
    .EDGE_SELECT_PIN(EDGE_SELECT_PIN), .DUTY_STABILIZER_ENABLE(DUTY),
    .DDR_CLOCK_PHASE_SELECT(PHASE), .DOUBLE_RATE_DISABLE(DRD), .OUTPUT_SWING_SELECT(SWING),
    .OUTPUT_EDGE_SELECT(EDGE), .LAUNCH_MODE(LAUNCH_MODE), .WRITE_STROBE(WRITE_STROBE));
  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  function automatic logic [7:0] exp_cfg(input logic [4:0] v);
    return {1'h0, v[4], v[3] & ~v[2], v[2:0], v[2], v[2] ? v[0] : v[3]};
  endfunction
  task automatic send_frame(input logic [28:0] frm, input int nbits, output logic seen);
    seen = 1'h0;
    occfg_host_inst.send(frm, nbits);
    for (int i = 0; i < 8 && !seen; i++) begin
      @(negedge CLK_SYS);
      seen = WRITE_STROBE === 1'h1;
    end
    @(negedge CLK_SYS);
  endtask
  task automatic write_cfg(input logic [4:0] v);
    logic seen;
    send_frame({1'h0, `OCCFG_HDR_PATTERN, `OCCFG_CFG_ADDR, 3'h5, v, 8'hff}, 28, seen);
    if (!seen) begin
      bad_count++;
      $display("mismatch at %0t: no write strobe", $time);
      print_verdict();
    end
  endtask
  task automatic t_fields();
    logic [4:0] tbl [6] = '{5'h08, 5'h04, 5'h0d, 5'h03, 5'h0e, 5'h15};
    check(cfg, exp_cfg(5'h12));
    foreach (tbl[i]) begin
      write_cfg(tbl[i]);
      check(cfg, exp_cfg(tbl[i]));
    end
  endtask
  task automatic t_refuse();
    logic seen;
    logic [27:0] tbl [4] = '{28'ha520000, 28'ha5f0000, 28'ha500000, 28'h5a1a0ff};
    foreach (tbl[i]) begin
      send_frame({1'h0, tbl[i]}, 28, seen);
      check({seen, cfg[6:0]}, exp_cfg(5'h15));
    end
    // one bit short, then one bit over, of an otherwise good frame
    send_frame({1'h0, 28'ha51a0ff} >> 1, 27, seen);
    check({seen, cfg[6:0]}, exp_cfg(5'h15));
    send_frame({28'ha51a0ff, 1'h1}, 29, seen);
    check({seen, cfg[6:0]}, exp_cfg(5'h15));
  endtask
  task automatic t_reset();
    RST_B = 1'h0;
    repeat (2) @(negedge CLK_SYS);
    check(cfg, exp_cfg(5'h12));
    RST_B = 1'h1;
    repeat (2) @(negedge CLK_SYS);
    check(cfg, exp_cfg(5'h12));
  endtask
  task automatic t_normal();
    EXT_MODE = 1'h0;
    for (int i = 0; i < 4; i++) begin
      {SWING_SELECT_PIN, EDGE_SELECT_PIN} = i[1:0];
      repeat (2) @(negedge CLK_SYS);
      check(cfg, {4'h4, i[1:0], 2'h0});
    end
    write_cfg(5'h0d);
    check(cfg, {4'h4, 2'h3, 2'h0});
    EXT_MODE = 1'h1;
    repeat (2) @(negedge CLK_SYS);
    check(cfg, exp_cfg(5'h0d));
  endtask
  initial begin
    @(negedge CLK_SYS);
    RST_B = 1'h0;
    repeat (2) @(negedge CLK_SYS);
    RST_B = 1'h1;
    @(negedge CLK_SYS);
    t_fields();
    t_refuse();
    t_reset();
    t_normal();
    print_verdict();
  end
endmodule // occfg_top_tb_top
